// ===== rtl/spi_master.sv
// serial port used as a master-only spi engine, with axi4-lite registers
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module spi_master #(
  parameter int RX_DEPTH = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // spi pins
  output logic sclk_o,
  output logic sclk_oe,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_used,
  // interrupt requests and service acknowledge
  output logic irq_rx_done,
  output logic irq_tx_done,
  output logic irq_buf_empty,
  input wire logic tx_done_ack
);
  rx_buf_if #(.WIDTH(8)) rb ();
  rx_fifo #(.DEPTH(RX_DEPTH)) u_rx_fifo (.aclk(aclk), .aresetn(aresetn), .rb(rb));

  // axi state
  logic [7:0] awaddr_q, awaddr_d;
  logic aw_v_q, aw_v_d, w_v_q, w_v_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  // registers and engine state
  logic [7:0] ctrl_q, ctrl_d, mode_q, mode_d, txbuf_q, txbuf_d, txs_q, txs_d, rxs_q, rxs_d;
  logic [7:0] hold_q, hold_d;
  logic [11:0] baud_q, baud_d;
  logic gie_q, gie_d, tx_done_q, tx_done_d, txfull_q, txfull_d, hold_v_q, hold_v_d;
  logic sclk_q, sclk_d;
  logic [3:0] edge_q, edge_d;
  spi_pkg::eng_state_t state_q, state_d;
  logic miso_s1_q, miso_s2_q;
  // helpers
  logic wr_fire, rd_fire, tick, run, tx_active, frame_done, lsb_first, cpha, lead;
  logic [7:0] status, rd_val, rx_new;
  logic rd_ok;

  assign lsb_first = mode_q[spi_pkg::MD_ORDER];
  assign cpha = mode_q[spi_pkg::MD_PHASE];
  // pending and ongoing work keeps the transmitter alive after disable
  assign tx_active = ctrl_q[spi_pkg::CT_TX_EN] || state_q == spi_pkg::ENG_SHIFT || txfull_q;
  assign run = tx_active && mode_q[7:6] == spi_pkg::SEL_MASTER_SPI;
  // the three receiver error positions stay zero, as do 4:0
  assign status = {rb.valid, tx_done_q, !txfull_q, 5'h00};

  baud_gen #(.DIV_W(12)) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run && state_q == spi_pkg::ENG_SHIFT),
    .div(baud_q),
    .tick(tick)
  );

  // miso passes two flops before the sampler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= miso_i;
      miso_s2_q <= miso_s1_q;
    end
  end

  // pins: clock idles at polarity; no select pin exists
  assign sclk_o = sclk_q;
  assign sclk_oe = tx_active;
  assign mosi_o = lsb_first ? txs_q[0] : txs_q[7];
  assign mosi_oe = tx_active;
  assign miso_used = ctrl_q[spi_pkg::CT_RX_EN];
  assign irq_rx_done = ctrl_q[spi_pkg::CT_RX_IE] && gie_q && rb.valid;
  assign irq_tx_done = ctrl_q[spi_pkg::CT_TX_IE] && gie_q && tx_done_q;
  assign irq_buf_empty = ctrl_q[spi_pkg::CT_EMPTY_IE] && gie_q && !txfull_q;

  // axi handshakes: one write and one read in flight
  assign s_axi_awready = !aw_v_q && !bvalid_q;
  assign s_axi_wready = !w_v_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_v_q && w_v_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;

  // read mux; reading data is the only read with a side effect (pop)
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      spi_pkg::OFF_DATA: rd_val = rb.rdata;
      spi_pkg::OFF_STATUS: rd_val = status;
      spi_pkg::OFF_CTRL: rd_val = {ctrl_q[7:3], spi_pkg::CTRL_RESET[2:0]};
      spi_pkg::OFF_MODE: rd_val = mode_q;
      spi_pkg::OFF_BAUD: rd_val = baud_q[7:0];
      spi_pkg::OFF_GIE: rd_val = {7'h00, gie_q};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // axi channel next state
  always_comb begin
    awaddr_d = awaddr_q;
    aw_v_d = aw_v_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_v_d = w_v_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d = s_axi_awaddr;
      aw_v_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_v_d = 1'b1;
    end
    if (wr_fire) begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q <= spi_pkg::OFF_GIE && awaddr_q[1:0] == 2'h0) ?
                spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d = s_axi_araddr == spi_pkg::OFF_BAUD ? {20'h00000, baud_q} : {24'h000000, rd_val};
      rresp_d = rd_ok ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      aw_v_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_v_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= spi_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= spi_pkg::RESP_OKAY;
    end else begin
      awaddr_q <= awaddr_d;
      aw_v_q <= aw_v_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_v_q <= w_v_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // receive byte as it will look after a sample on this tick
  assign lead = !edge_q[0];
  assign frame_done = state_q == spi_pkg::ENG_SHIFT && tick && edge_q == spi_pkg::LAST_EDGE;
  assign rx_new = lsb_first ? {miso_s2_q, rxs_q[7:1]} : {rxs_q[6:0], miso_s2_q};

  // registers, shift engine and receive staging
  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    baud_d = baud_q;
    gie_d = gie_q;
    txbuf_d = txbuf_q;
    txfull_d = txfull_q;
    tx_done_d = tx_done_q;
    state_d = state_q;
    txs_d = txs_q;
    rxs_d = rxs_q;
    edge_d = edge_q;
    sclk_d = sclk_q;
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    rb.push = 1'b0;
    rb.wdata = rx_new;
    rb.pop = rd_fire && s_axi_araddr == spi_pkg::OFF_DATA;
    rb.flush = !ctrl_q[spi_pkg::CT_RX_EN];
    // clear first so that a same-cycle completion wins
    if (tx_done_ack) begin
      tx_done_d = 1'b0;
    end
    if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        spi_pkg::OFF_DATA: begin
          // writes while disabled or full are dropped; software polls empty
          if (ctrl_q[spi_pkg::CT_TX_EN] && !txfull_q) begin
            txbuf_d = wdata_q[7:0];
            txfull_d = 1'b1;
          end
        end
        spi_pkg::OFF_STATUS: begin
          if (wdata_q[spi_pkg::ST_TX_DONE]) begin
            tx_done_d = 1'b0;
          end
        end
        spi_pkg::OFF_CTRL: ctrl_d = {wdata_q[7:3], spi_pkg::CTRL_RESET[2:0]};
        spi_pkg::OFF_MODE: mode_d = wdata_q[7:0] & spi_pkg::MODE_RW_MASK;
        spi_pkg::OFF_BAUD: baud_d[7:0] = wdata_q[7:0];
        spi_pkg::OFF_GIE: gie_d = wdata_q[0];
        default: ;
      endcase
    end
    if (wr_fire && wstrb_q[1] && awaddr_q == spi_pkg::OFF_BAUD) begin
      baud_d[11:8] = wdata_q[11:8];
    end
    // held byte drains into the buffer once room appears
    if (hold_v_q && !rb.full) begin
      rb.push = 1'b1;
      rb.wdata = hold_q;
      hold_v_d = 1'b0;
    end
    case (state_q)
      spi_pkg::ENG_IDLE: begin
        sclk_d = mode_q[spi_pkg::MD_POL];
        if (txfull_q && run) begin
          txs_d = txbuf_q;
          txfull_d = 1'b0;
          edge_d = 4'h0;
          state_d = spi_pkg::ENG_SHIFT;
        end
      end
      spi_pkg::ENG_SHIFT: begin
        if (tick) begin
          sclk_d = !sclk_q;
          edge_d = edge_q + 1'b1;
          // sample on leading edge for phase 0, trailing for phase 1
          if (lead ^ cpha) begin
            rxs_d = rx_new;
          end else if (edge_q != 4'h0) begin
            txs_d = lsb_first ? {1'b0, txs_q[7:1]} : {txs_q[6:0], 1'b0};
          end
        end
        if (frame_done) begin
          if (ctrl_q[spi_pkg::CT_RX_EN]) begin
            // a full buffer refuses the byte; it waits in hold, overwritten by newer
            if (!hold_v_q && !rb.full) begin
              rb.push = 1'b1;
              rb.wdata = cpha ? rx_new : rxs_q; // phase 0 took its last bit an edge ago
            end else begin
              hold_d = cpha ? rx_new : rxs_q;
              hold_v_d = 1'b1;
            end
          end
          if (txfull_q && run) begin
            txs_d = txbuf_q;
            txfull_d = 1'b0;
            edge_d = 4'h0;
          end else begin
            state_d = spi_pkg::ENG_IDLE;
            tx_done_d = 1'b1;
          end
        end
      end
      default: state_d = spi_pkg::ENG_IDLE;
    endcase
    if (!ctrl_q[spi_pkg::CT_RX_EN]) begin
      hold_v_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= spi_pkg::CTRL_RESET;
      mode_q <= spi_pkg::MODE_RESET;
      baud_q <= spi_pkg::BAUD_RESET;
      gie_q <= 1'b0;
      txbuf_q <= 8'h00;
      txfull_q <= 1'b0;
      tx_done_q <= 1'b0;
      state_q <= spi_pkg::ENG_IDLE;
      txs_q <= 8'h00;
      rxs_q <= 8'h00;
      edge_q <= 4'h0;
      sclk_q <= 1'b0;
      hold_q <= 8'h00;
      hold_v_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      baud_q <= baud_d;
      gie_q <= gie_d;
      txbuf_q <= txbuf_d;
      txfull_q <= txfull_d;
      tx_done_q <= tx_done_d;
      state_q <= state_d;
      txs_q <= txs_d;
      rxs_q <= rxs_d;
      edge_q <= edge_d;
      sclk_q <= sclk_d;
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  status_zero_a: assert property ((rd_fire && s_axi_araddr == spi_pkg::OFF_STATUS) |=>
    s_axi_rdata[4:0] == 5'h00) else $error("status low bits not zero");
  rx_flush_a: assert property (!ctrl_q[spi_pkg::CT_RX_EN] |=> !rb.valid)
    else $error("receive buffer kept data while receiver disabled");
  empty_clear_a: assert property ((wr_fire && wstrb_q[0] &&
    awaddr_q == spi_pkg::OFF_DATA && ctrl_q[spi_pkg::CT_TX_EN] && !txfull_q) |=>
    !status[spi_pkg::ST_BUF_EMPTY]) else $error("data write did not clear buffer empty");
  sclk_idle_a: assert property ((state_q == spi_pkg::ENG_IDLE) |=>
    sclk_o == $past(mode_q[spi_pkg::MD_POL])) else $error("idle clock level wrong");
  tx_done_set_a: assert property ((frame_done && !txfull_q) |=> tx_done_q)
    else $error("transmit complete not set");
  tx_done_clr_a: assert property ((tx_done_ack && !frame_done) |=> !tx_done_q)
    else $error("transmit complete not cleared");
  no_clock_idle_a: assert property ((state_q == spi_pkg::ENG_IDLE && !txfull_q)
    |=> state_q == spi_pkg::ENG_IDLE) else $error("clock started without a write");
  no_overflow_a: assert property (!(rb.push && rb.full))
    else $error("push into full receive buffer");
  irq_empty_a: assert property (irq_buf_empty |-> gie_q && !txfull_q)
    else $error("empty interrupt without its conditions");
  irq_rx_a: assert property (irq_rx_done |-> gie_q && rb.valid)
    else $error("receive interrupt without its conditions");
  irq_tx_a: assert property (irq_tx_done |-> gie_q && tx_done_q)
    else $error("transmit interrupt without its conditions");
endmodule

// ===== rtl/spi_pkg.sv
// constants, register map and types for the serial port in master spi mode
package spi_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_BAUD = 8'h10;
  localparam logic [7:0] OFF_GIE = 8'h14;
  // status fields
  localparam int ST_RX_DONE = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_BUF_EMPTY = 5;
  // control fields
  localparam int CT_RX_IE = 7;
  localparam int CT_TX_IE = 6;
  localparam int CT_EMPTY_IE = 5;
  localparam int CT_RX_EN = 4;
  localparam int CT_TX_EN = 3;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  // mode fields
  localparam int MD_SEL_LO = 6;
  localparam int MD_ORDER = 2;
  localparam int MD_PHASE = 1;
  localparam int MD_POL = 0;
  localparam logic [7:0] MODE_RESET = 8'h06;
  localparam logic [7:0] MODE_RW_MASK = 8'hC7;
  localparam logic [1:0] SEL_MASTER_SPI = 2'h3;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  // frame shape: eight bits, two clock edges each
  localparam logic [3:0] LAST_EDGE = 4'hF;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ENG_IDLE, ENG_SHIFT} eng_state_t;
endpackage

// ===== rtl/rx_buf_if.sv
// carrier between the shift engine and the receive buffer
`timescale 1ns/1ps
interface rx_buf_if #(parameter int WIDTH = 8);
  logic push;
  logic [WIDTH-1:0] wdata;
  logic full;
  logic pop;
  logic flush;
  logic [WIDTH-1:0] rdata;
  logic valid;
  modport engine (output push, wdata, pop, flush, input full, rdata, valid);
  modport buffer (input push, wdata, pop, flush, output full, rdata, valid);
endinterface

// ===== rtl/rx_fifo.sv
// small receive buffer; new bytes are refused while full
`timescale 1ns/1ps
module rx_fifo #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // buffer side of the carrier
  rx_buf_if.buffer rb
);
  localparam int AW = $clog2(DEPTH);
  logic [rb.WIDTH-1:0] mem_q [DEPTH];
  logic [rb.WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] cnt_q, cnt_d;
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;

  assign rb.full = (cnt_q == (AW+1)'(DEPTH));
  assign rb.valid = (cnt_q != '0);
  assign rb.rdata = mem_q[rd_q];

  // pointers wrap at the depth; flush drops everything
  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    wr_d = wr_q;
    if (rb.flush) begin
      cnt_d = '0;
      rd_d = '0;
      wr_d = '0;
    end else begin
      if (rb.push && !rb.full) begin
        mem_d[wr_q] = rb.wdata;
        wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        cnt_d = cnt_d + 1'b1;
      end
      if (rb.pop && rb.valid) begin
        rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        cnt_d = cnt_d - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      rd_q <= '0;
      wr_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end

  // storage needs no reset, occupancy guards it
  always_ff @(posedge aclk) begin
    mem_q <= mem_d;
  end
endmodule

// ===== rtl/baud_gen.sv
// half-period tick generator for the serial clock
`timescale 1ns/1ps
module baud_gen #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  // one-cycle tick every div+1 cycles while running
  output logic tick
);
  logic [DIV_W-1:0] cnt_q, cnt_d;

  // counter restarts while stopped so a new frame gets a full half period
  always_comb begin
    tick = run && (cnt_q == div);
    if (!run || tick) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tick_period_a: assert property ((run && tick && div == '0) |=> (tick || !run))
    else $error("divisor zero did not tick every cycle");
endmodule

// ===== test/spi_slave_model.sv
// behavioural spi slave that answers the serial port under test
`timescale 1ns/1ps
module spi_slave_model (
  // serial pins
  input wire logic sclk,
  input wire logic oe,
  input wire logic mosi,
  output logic miso,
  // frame shape and reply data
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] reply,
  output logic [7:0] got,
  output logic [7:0] nf
);
  int n;
  logic last;
  logic [7:0] sh;
  logic [7:0] cur;
  initial begin
    n = 0;
    last = 1'b0;
    miso = 1'b0;
    got = 8'h00;
    nf = 8'h00;
    sh = 8'h00;
  end
  // reply byte steps by one per frame so lost bytes can be told apart
  always @(sclk or oe or reply) begin
    cur = reply + nf;
    if (!oe) begin
      miso = ~miso; // released line must not look like held data
      n = 0;
    end else if (sclk !== last && sclk === ~(cpol ^ cpha)) begin
      sh[lsb ? n : 7 - n] = mosi;
      n = n + 1;
      if (n == 8) begin
        got = sh;
        nf = nf + 8'h01;
        n = 0;
      end
    end else begin
      miso = lsb ? cur[n] : cur[7 - n];
    end
    last = sclk;
  end
endmodule

// ===== test/usart_master_spi_mode_tb.sv
// self-checking bench for the serial port in master spi mode
`timescale 1ns/1ps
module usart_master_spi_mode_tb;
  localparam logic [7:0] A_DAT = spi_pkg::OFF_DATA;
  localparam logic [7:0] A_ST = spi_pkg::OFF_STATUS;
  localparam logic [7:0] A_CT = spi_pkg::OFF_CTRL;
  localparam logic [7:0] A_MD = spi_pkg::OFF_MODE;
  localparam logic [7:0] A_BD = spi_pkg::OFF_BAUD;
  localparam logic [7:0] A_GI = spi_pkg::OFF_GIE;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, miso, ack;
  logic awready, wready, bvalid, arready, rvalid, sclk, sclk_oe, mosi, mosi_oe;
  logic miso_used, irq_rx, irq_tx, irq_em, cpol, cpha, lsb, sclk_prev;
  logic [7:0] awaddr, araddr, reply, got, nf;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, wresp;
  int num_errors, n_compared, cyc, n_edge, last_t, gap;

  spi_master dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclk_o(sclk), .sclk_oe(sclk_oe),
    .mosi_o(mosi), .mosi_oe(mosi_oe), .miso_i(miso), .miso_used(miso_used),
    .irq_rx_done(irq_rx), .irq_tx_done(irq_tx), .irq_buf_empty(irq_em),
    .tx_done_ack(ack));
  spi_slave_model slave_u (.sclk(sclk), .oe(sclk_oe), .mosi(mosi), .miso(miso),
    .cpol(cpol), .cpha(cpha), .lsb(lsb), .reply(reply), .got(got), .nf(nf));

  always #2.5 aclk = ~aclk;
  // serial clock edges and their spacing in system cycles; hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sclk_prev <= sclk;
    if (sclk_prev !== sclk) begin
      n_edge <= n_edge + 1;
      gap <= cyc - last_t;
      last_t <= cyc;
    end
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end

  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // one write; address and data released each as soon as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no count of its own: only the bench timeout ends a stuck wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        wresp = bresp;
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        rd_v = rdata;
        resp = rresp;
      end
    end while (rready);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, {spi_pkg::RESP_OKAY, e}, {resp, rd_v});
  endtask
  // polling never makes clock pulses, so it is safe during frames
  task automatic wait_st(input int b);
    do begin
      rd(A_ST);
    end while (rd_v[b] !== 1'b1);
  endtask
  task automatic setup(input logic [2:0] m, input logic [11:0] b);
    wr(A_CT, 32'h00);
    wr(A_BD, 32'h00);
    wr(A_MD, {24'h0, spi_pkg::SEL_MASTER_SPI, 3'h0, m});
    {lsb, cpha, cpol} <= m;
    wr(A_CT, 32'h18);
    wr(A_BD, {20'h0, b});
  endtask

  task automatic t_regs;
    rchk("status", A_ST, 32'h20);
    rchk("control", A_CT, 32'h06);
    rchk("mode", A_MD, 32'h06);
    rd(8'h18);
    chk("unmapped", {spi_pkg::RESP_SLVERR, 32'h0}, {resp, rd_v});
    wr(8'h18, 32'h0);
    chk("unmapped write", spi_pkg::RESP_SLVERR, wresp);
    wr(A_MD, 32'hFF);
    chk("write resp", spi_pkg::RESP_OKAY, wresp);
    rchk("mode rw", A_MD, 32'hC7);
    wr(A_CT, 32'hFF);
    rchk("control rw", A_CT, 32'hFE);
    chk("masked irqs", 3'h0, {irq_rx, irq_tx, irq_em});
    wr(A_GI, 32'h01);
    chk("empty irq", 3'h1, {irq_rx, irq_tx, irq_em});
  endtask
  task automatic t_noclk;
    int e0;
    setup(3'h0, 12'h002);
    wr(A_CT, 32'h10);
    e0 = n_edge;
    wr(A_DAT, 32'h5A);
    rd(A_DAT);
    rchk("no tx", A_ST, 32'h20);
    chk("no clock", e0, n_edge);
    chk("tx pins", 2'h0, {sclk_oe, mosi_oe});
  endtask
  task automatic t_modes;
    logic [7:0] x;
    logic [7:0] d;
    int e0;
    for (int m = 0; m < 8; m++) begin
      setup(m[2:0], 12'(m + 2));
      x = reply + nf;
      d = 8'hA1 ^ 8'(m * 17);
      e0 = n_edge;
      wr(A_DAT, {24'h0, d});
      wait_st(spi_pkg::ST_RX_DONE);
      chk("sent", d, got);
      chk("edges", 16, n_edge - e0);
      chk("half period", m + 3, gap);
      chk("idle clock", cpol, sclk);
      chk("pins", 3'h7, {sclk_oe, mosi_oe, miso_used});
      rchk("rx byte", A_DAT, {24'h0, x});
      rchk("status", A_ST, 32'h60);
      wr(A_ST, 32'h40);
      rchk("tx clear", A_ST, 32'h20);
    end
  endtask
  task automatic t_overflow;
    logic [7:0] x;
    setup(3'h0, 12'h003);
    x = reply + nf;
    wr(A_DAT, 32'h11);
    wr(A_DAT, 32'h22);
    rchk("buffered", A_ST, 32'h00);
    wait_st(spi_pkg::ST_BUF_EMPTY);
    wr(A_DAT, 32'h33);
    wait_st(spi_pkg::ST_BUF_EMPTY);
    wr(A_DAT, 32'h44);
    wait_st(spi_pkg::ST_TX_DONE);
    chk("last sent", 8'h44, got);
    rchk("first", A_DAT, {24'h0, x});
    rchk("second", A_DAT, {24'h0, 8'(x + 1)});
    rchk("fourth", A_DAT, {24'h0, 8'(x + 3)});
    rchk("drained", A_ST, 32'h60);
    wr(A_DAT, 32'h55);
    wait_st(spi_pkg::ST_RX_DONE);
    wr(A_CT, 32'h08);
    rchk("flushed", A_ST, 32'h60);
    chk("rx pin", 1'b0, miso_used);
  endtask
  task automatic t_irq;
    wr(A_CT, 32'hF8);
    chk("irq idle", 3'h3, {irq_rx, irq_tx, irq_em});
    @(posedge aclk);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    rchk("serviced", A_ST, 32'h20);
    chk("irq tx", 1'b0, irq_tx);
    wr(A_DAT, 32'h66);
    wait_st(spi_pkg::ST_RX_DONE);
    chk("irq frame", 3'h7, {irq_rx, irq_tx, irq_em});
    wr(A_GI, 32'h00);
    chk("irq global", 3'h0, {irq_rx, irq_tx, irq_em});
    rd(A_DAT);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ack} = 6'h00;
    {cpol, cpha, lsb, sclk_prev} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    reply = 8'h3C;
    {num_errors, n_compared, cyc, n_edge, last_t, gap} = {6{32'h0}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_noclk;
    t_modes;
    t_overflow;
    t_irq;
    stop_test;
  end
endmodule
